// File: rtl/rx_path_ctl.sv
`timescale 1ns/1ps
`default_nettype none
`include "rx_ctl_consts.svh"
module rx_path_ctl (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`PCS_LANE_COUNT-1:0] lane_valid,
  input wire logic [64*`PCS_LANE_COUNT-1:0] lane_data,
  input wire logic in_valid,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire rx_ctl_pkg::mty_type in_mty,
  input wire logic [63:0] in_data,
  input wire logic [63:0] in_preamble,
  input wire logic in_fcs_bad,
  output logic out_valid,
  output logic out_sop,
  output logic out_eop,
  output rx_ctl_pkg::mty_type out_mty,
  output logic [63:0] out_data,
  output logic out_err,
  output logic pcs_decode_hold,
  output logic realign_restart,
  output logic rate_40g,
  output logic stat_good,
  output logic stat_bad,
  output logic stat_bad_fcs,
  output logic [`PCS_LANE_COUNT-1:0] marker_spacing_error
);
  import rx_ctl_pkg::*;
  rx_cfg_if cfg (); // register fields and status
  frame_state_type state_q;
  logic en_q; // receive enable in force
  // per-frame copies of the controls
  logic [14:0] max_q;
  logic [7:0] min_q;
  logic strip_q;
  logic ign_q;
  logic pre_err_q; // preamble or delimiter fault
  logic [15:0] len_q; // bytes taken so far
  // one-word hold and a trailing word
  logic hold_v_q;
  logic [63:0] hold_data_q;
  logic hold_sop_q;
  logic tail_v_q;
  logic [63:0] tail_data_q;
  mty_type tail_mty_q;
  logic tail_err_q;
  // word decisions
  logic sop_ok, take, last, over, short_fr, fcs_err, err, strip_now, ign_now, pre_now;
  logic [15:0] max_now, base, nlen, len_fin;
  logic [7:0] min_now;
  logic [3:0] wb, k, s;
  mty_type strip_mty;
  // emission of the next output word
  logic e_v, e_sop, e_eop, e_err;
  logic [63:0] e_data;
  mty_type e_mty;

  // valid bytes of an incoming word
  function automatic logic [3:0] word_bytes(input logic eop, input mty_type mty);
    return eop ? (`WORD_BYTES - {1'b0, mty}) : `WORD_BYTES;
  endfunction

  rx_ctl_regs u_regs (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg.regs)
  );

  // one spacing checker per lane
  for (genvar i = 0; i < `PCS_LANE_COUNT; i++) begin : g_lane
    lane_marker_check u_lm (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .clr(cfg.resync),
      .word_valid(lane_valid[i]),
      .word(lane_data[64*i +: 64]),
      .pattern(cfg.lane_marker_pattern[i]),
      .spacing_m1(cfg.marker_spacing_m1),
      .spacing_err(cfg.spacing_err[i])
    );
  end

  assign marker_spacing_error = cfg.spacing_err;
  assign cfg.en_active = en_q;
  assign cfg.in_frame = (state_q != IDLE_ST);
  assign rate_40g = cfg.rate_40g;
  assign pcs_decode_hold = !en_q;

  // frame start and per-word length bookkeeping
  always_comb begin
    sop_ok = in_valid && in_sop && (state_q == IDLE_ST) && en_q;
    take = sop_ok || (in_valid && (state_q == RECV_ST));
    max_now = sop_ok ? {1'b0, cfg.max_len} : {1'b0, max_q};
    min_now = sop_ok ? cfg.min_len : min_q;
    strip_now = sop_ok ? cfg.strip : strip_q;
    ign_now = sop_ok ? cfg.ign_fcs : ign_q;
    pre_now = (cfg.chk_pre && (in_preamble[55:0] != `PREAMBLE_VAL)) ||
      (cfg.chk_sfd && (in_preamble[63:56] != `SFD_VAL));
    base = sop_ok ? 16'h0000 : len_q;
    wb = word_bytes(in_eop, in_mty);
    nlen = base + {12'h000, wb};
    over = nlen > max_now;
    last = take && (in_eop || over);
    len_fin = over ? max_now : nlen;
    k = over ? 4'(max_now - base) : wb;
    s = (strip_now && !over && (len_fin > `STRIP_MIN)) ? `FCS_BYTES : 4'h0;
    strip_mty = 3'(s - k);
    short_fr = len_fin < `SHORT_LIMIT;
    fcs_err = in_eop && in_fcs_bad && !over;
    err = (sop_ok ? pre_now : pre_err_q) || over || (len_fin < {8'h00, min_now}) ||
      (fcs_err && !ign_now);
  end

  // next output word
  always_comb begin
    e_v = 1'b0;
    e_data = hold_data_q;
    e_sop = hold_sop_q;
    e_eop = 1'b0;
    e_mty = 3'h0;
    e_err = 1'b0;
    if (tail_v_q) begin
      // trailing word of the previous frame
      e_v = 1'b1;
      e_data = tail_data_q;
      e_sop = 1'b0;
      e_eop = 1'b1;
      e_mty = tail_mty_q;
      e_err = tail_err_q;
    end else if (take && !last) begin
      // mid frame: release the held word
      e_v = hold_v_q;
    end else if (last && !short_fr) begin
      if (k <= s) begin
        // fcs covers the whole last word: the held word ends the frame
        e_v = hold_v_q;
        e_eop = 1'b1;
        e_mty = strip_mty;
        e_err = err;
      end else if (hold_v_q) begin
        e_v = 1'b1;
      end else begin
        e_v = 1'b1;
        e_data = in_data;
        e_sop = sop_ok;
        e_eop = 1'b1;
        e_mty = 3'(`WORD_BYTES - (k - s));
        e_err = err;
      end
    end
  end

  // frame state machine
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= IDLE_ST;
    end else if (ce) begin
      if (cfg.resync) begin
        state_q <= IDLE_ST;
      end else begin
        case (state_q)
          IDLE_ST, RECV_ST: begin
            if (last) state_q <= (over && !in_eop) ? DISCARD_ST : IDLE_ST;
            else if (take) state_q <= RECV_ST;
          end
          DISCARD_ST: begin
            // drop the rest of a truncated frame
            if (in_valid && in_eop) state_q <= IDLE_ST;
          end
          default: state_q <= IDLE_ST;
        endcase
      end
    end
  end

  // enable changes only between frames
  always_ff @(posedge sys_clk) begin
    if (rst) en_q <= 1'b0;
    else if (ce && (state_q == IDLE_ST) && !sop_ok) en_q <= cfg.rx_en;
  end

  // per-frame control copies and length
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      max_q <= `RST_MAXLEN;
      min_q <= `RST_MINLEN;
      strip_q <= 1'b0;
      ign_q <= 1'b0;
      pre_err_q <= 1'b0;
      len_q <= 16'h0000;
    end else if (ce) begin
      if (sop_ok) begin
        max_q <= cfg.max_len;
        min_q <= cfg.min_len;
        strip_q <= cfg.strip;
        ign_q <= cfg.ign_fcs;
        pre_err_q <= pre_now;
      end
      if (take) len_q <= nlen;
    end
  end

  // hold, tail and output registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold_v_q <= 1'b0;
      hold_data_q <= 64'h0;
      hold_sop_q <= 1'b0;
      tail_v_q <= 1'b0;
      tail_data_q <= 64'h0;
      tail_mty_q <= 3'h0;
      tail_err_q <= 1'b0;
      out_valid <= 1'b0;
      out_sop <= 1'b0;
      out_eop <= 1'b0;
      out_mty <= 3'h0;
      out_data <= 64'h0;
      out_err <= 1'b0;
    end else if (ce) begin
      out_valid <= e_v && !cfg.resync;
      out_sop <= e_sop;
      out_eop <= e_eop;
      out_mty <= e_mty;
      out_data <= e_data;
      out_err <= e_err;
      tail_v_q <= 1'b0;
      if (cfg.resync) begin
        hold_v_q <= 1'b0;
      end else if (take && !last) begin
        hold_v_q <= 1'b1;
        hold_data_q <= in_data;
        hold_sop_q <= sop_ok;
      end else if (last) begin
        hold_v_q <= 1'b0;
        // final word left after stripping goes out next cycle
        tail_v_q <= !short_fr && (k > s) && hold_v_q;
        tail_data_q <= in_data;
        tail_mty_q <= 3'(`WORD_BYTES - (k - s));
        tail_err_q <= err;
      end
    end
  end

  // statistics pulses at frame end and the realign restart pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_good <= 1'b0;
      stat_bad <= 1'b0;
      stat_bad_fcs <= 1'b0;
      realign_restart <= 1'b0;
    end else if (ce) begin
      stat_good <= last && !short_fr && !err;
      stat_bad <= last && !short_fr && err;
      stat_bad_fcs <= last && fcs_err;
      realign_restart <= cfg.resync;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !ce);
  property p_en_stable;
    state_q != IDLE_ST |=> $stable(en_q);
  endproperty
  a_en_stable: assert property (p_en_stable) else $error("enable moved mid frame");
  property p_idle_off;
    !en_q [*3] |-> !out_valid && !stat_good && !stat_bad;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("activity while disabled");
  property p_pre;
    sop_ok && cfg.chk_pre && in_preamble[55:0] != `PREAMBLE_VAL |=> pre_err_q;
  endproperty
  a_pre: assert property (p_pre) else $error("bad preamble missed");
  property p_sfd;
    sop_ok && cfg.chk_sfd && in_preamble[63:56] != `SFD_VAL |=> pre_err_q;
  endproperty
  a_sfd: assert property (p_sfd) else $error("bad delimiter missed");
  property p_resync;
    cfg.resync |=> realign_restart && state_q == IDLE_ST && !out_valid;
  endproperty
  a_resync: assert property (p_resync) else $error("realign did not reset path");
  property p_strip;
    last && !short_fr && s == `FCS_BYTES && k <= s |=>
      out_valid && out_eop && out_mty == $past(strip_mty);
  endproperty
  a_strip: assert property (p_strip) else $error("fcs strip end wrong");
  property p_keep_fcs;
    last && !over && len_fin <= `STRIP_MIN |-> s == 4'h0;
  endproperty
  a_keep_fcs: assert property (p_keep_fcs) else $error("short frame stripped");
  property p_fcs_err;
    last && !short_fr && fcs_err && !ign_now |-> ##[1:2] (out_valid && out_eop && out_err);
  endproperty
  a_fcs_err: assert property (p_fcs_err) else $error("bad fcs not flagged");
  property p_fcs_mask;
    last && !short_fr && fcs_err && ign_now && !err |=> stat_good && stat_bad_fcs;
  endproperty
  a_fcs_mask: assert property (p_fcs_mask) else $error("masked fcs miscounted");
  property p_trunc;
    last && over && !short_fr |-> ##[1:2] (out_valid && out_eop && out_err);
  endproperty
  a_trunc: assert property (p_trunc) else $error("oversize not flagged");
  property p_short;
    last && short_fr && !tail_v_q |=> !out_valid && !stat_good && !stat_bad;
  endproperty
  a_short: assert property (p_short) else $error("runt delivered");
  property p_under;
    last && !short_fr && len_fin < {8'h00, min_now} |-> ##[1:2] (out_eop && out_err);
  endproperty
  a_under: assert property (p_under) else $error("undersize not flagged");
  property p_latch;
    state_q != IDLE_ST |=> $stable(max_q) && $stable(strip_q) && $stable(ign_q);
  endproperty
  a_latch: assert property (p_latch) else $error("controls moved mid frame");
  c_tail: cover property (last && !short_fr && k > s && hold_v_q);
  c_runt: cover property (last && short_fr);
  c_trunc: cover property (last && over && !in_eop);
  c_resync: cover property (cfg.resync && state_q == RECV_ST);
endmodule
`default_nettype wire

// File: include/rx_ctl_consts.svh
`ifndef RX_CTL_CONSTS_SVH
`define RX_CTL_CONSTS_SVH
// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_MAXLEN 8'h04
`define OFF_MINLEN 8'h08
`define OFF_SPACING 8'h0C
`define OFF_STATUS 8'h10
`define OFF_PATTERN 8'h20
`define OFF_PAT_END 8'h40
// control register fields
`define CTRL_RATE 0
`define CTRL_ENABLE 1
`define CTRL_CHK_PRE 2
`define CTRL_CHK_SFD 3
`define CTRL_STRIP 4
`define CTRL_IGN_FCS 5
`define CTRL_RESYNC 6
// status register fields
`define STAT_SPACE_LSB 0
`define STAT_ENABLED 4
`define STAT_IN_FRAME 5
// reset values
`define RST_CTRL 6'h02
`define RST_MAXLEN 15'h2580
`define RST_MINLEN 8'h40
`define RST_SPACING 16'h3FFF
// frame figures
`define PREAMBLE_VAL 56'h55555555555555
`define SFD_VAL 8'hD5
`define WORD_BYTES 4'h8
`define FCS_BYTES 4'h4
`define SHORT_LIMIT 16'h0010
`define STRIP_MIN 16'h0008
`define PCS_LANE_COUNT 4
`endif

// File: include/rx_ctl_pkg.sv
package rx_ctl_pkg;
  // receive frame tracking states
  typedef enum logic [1:0] {
    IDLE_ST = 2'b00,
    RECV_ST = 2'b01,
    DISCARD_ST = 2'b10
  } frame_state_type;
  // one lane marker pattern
  typedef logic [63:0] pattern_type;
  // empty byte count of a last word
  typedef logic [2:0] mty_type;
endpackage

// File: include/rx_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "rx_ctl_consts.svh"
interface rx_cfg_if;
  logic rate_40g;
  logic rx_en;
  logic chk_pre;
  logic chk_sfd;
  logic strip;
  logic ign_fcs;
  logic resync;
  logic [14:0] max_len;
  logic [7:0] min_len;
  logic [15:0] marker_spacing_m1;
  rx_ctl_pkg::pattern_type lane_marker_pattern [`PCS_LANE_COUNT];
  logic [`PCS_LANE_COUNT-1:0] spacing_err;
  logic en_active;
  logic in_frame;
  modport regs (output rate_40g, rx_en, chk_pre, chk_sfd, strip, ign_fcs, resync, max_len,
    min_len, marker_spacing_m1, lane_marker_pattern, input spacing_err, en_active, in_frame);
  modport core (input rate_40g, rx_en, chk_pre, chk_sfd, strip, ign_fcs, resync, max_len,
    min_len, marker_spacing_m1, lane_marker_pattern, output spacing_err, en_active, in_frame);
endinterface
`default_nettype wire

// File: rtl/lane_marker_check.sv
`timescale 1ns/1ps
`default_nettype none
module lane_marker_check (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  input wire logic word_valid,
  input wire rx_ctl_pkg::pattern_type word,
  input wire rx_ctl_pkg::pattern_type pattern,
  input wire logic [15:0] spacing_m1,
  output logic spacing_err
);
  import rx_ctl_pkg::*;
  logic hit; // marker word seen this cycle
  logic seen_q; // a first marker has set the phase
  logic [15:0] cnt_q; // words since the last marker
  assign hit = word_valid && (word == pattern);
  // spacing count and spacing error, held until an on-time marker or clr
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seen_q <= 1'b0;
      cnt_q <= 16'h0000;
      spacing_err <= 1'b0;
    end else if (ce) begin
      if (clr) begin
        seen_q <= 1'b0;
        cnt_q <= 16'h0000;
        spacing_err <= 1'b0;
      end else if (hit) begin
        // marker on time clears, off time sets
        seen_q <= 1'b1;
        cnt_q <= 16'h0000;
        if (seen_q) spacing_err <= (cnt_q != spacing_m1);
      end else if (word_valid && seen_q) begin
        // a missing marker is also a spacing error
        if (cnt_q == spacing_m1) spacing_err <= 1'b1;
        if (cnt_q != 16'hFFFF) cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !ce || clr);
  property p_space_bad;
    hit && seen_q && cnt_q != spacing_m1 |=> spacing_err;
  endproperty
  a_space_bad: assert property (p_space_bad) else $error("late or early marker not flagged");
  property p_space_ok;
    hit && seen_q && cnt_q == spacing_m1 |=> !spacing_err;
  endproperty
  a_space_ok: assert property (p_space_ok) else $error("correct spacing did not clear");
endmodule
`default_nettype wire

// File: rtl/rx_ctl_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "rx_ctl_consts.svh"
module rx_ctl_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  rx_cfg_if.regs cfg
);
  import rx_ctl_pkg::*;
  logic wr; // access phase of a write
  logic [5:0] ctrl_q; // control bits, resync excluded
  logic [14:0] maxlen_q;
  logic [7:0] minlen_q;
  logic [15:0] spacing_q;
  logic resync_q; // one-cycle realign pulse
  logic [31:0] pat_q [2*`PCS_LANE_COUNT]; // pattern halves
  logic [31:0] rdata; // read mux
  logic hit; // address is mapped
  // pattern window decode
  function automatic logic is_pat(input logic [7:0] a);
    return (a >= `OFF_PATTERN) && (a < `OFF_PAT_END);
  endfunction
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  // writable configuration
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= `RST_CTRL;
      maxlen_q <= `RST_MAXLEN;
      minlen_q <= `RST_MINLEN;
      spacing_q <= `RST_SPACING;
    end else if (ce && wr) begin
      if (paddr == `OFF_CTRL) begin
        ctrl_q <= pwdata[5:0];
      end else if (paddr == `OFF_MAXLEN) begin
        maxlen_q <= pwdata[14:0];
      end else if (paddr == `OFF_MINLEN) begin
        minlen_q <= pwdata[7:0];
      end else if (paddr == `OFF_SPACING) begin
        spacing_q <= pwdata[15:0];
      end
    end
  end
  // pattern words
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 2*`PCS_LANE_COUNT; i++) pat_q[i] <= 32'h0000_0000;
    end else if (ce && wr && is_pat(paddr)) begin
      pat_q[paddr[4:2]] <= pwdata;
    end
  end
  // self-clearing realign request
  always_ff @(posedge sys_clk) begin
    if (rst) resync_q <= 1'b0;
    else if (ce) resync_q <= wr && (paddr == `OFF_CTRL) && pwdata[`CTRL_RESYNC];
  end
  // read mux
  always_comb begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == `OFF_CTRL) begin
      rdata[5:0] = ctrl_q;
    end else if (paddr == `OFF_MAXLEN) begin
      rdata[14:0] = maxlen_q;
    end else if (paddr == `OFF_MINLEN) begin
      rdata[7:0] = minlen_q;
    end else if (paddr == `OFF_SPACING) begin
      rdata[15:0] = spacing_q;
    end else if (paddr == `OFF_STATUS) begin
      rdata[`PCS_LANE_COUNT-1:0] = cfg.spacing_err;
      rdata[`STAT_ENABLED] = cfg.en_active;
      rdata[`STAT_IN_FRAME] = cfg.in_frame;
    end else if (is_pat(paddr)) begin
      rdata = pat_q[paddr[4:2]];
    end else begin
      hit = 1'b0;
    end
  end
  // answer captured in the setup phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce && psel && !penable) begin
      prdata <= rdata;
      pslverr <= !hit;
    end
  end
  // fields toward the core
  always_comb begin
    for (int i = 0; i < `PCS_LANE_COUNT; i++) begin
      cfg.lane_marker_pattern[i] = {pat_q[2*i+1], pat_q[2*i]};
    end
  end
  assign cfg.rate_40g = ctrl_q[`CTRL_RATE];
  assign cfg.rx_en = ctrl_q[`CTRL_ENABLE];
  assign cfg.chk_pre = ctrl_q[`CTRL_CHK_PRE];
  assign cfg.chk_sfd = ctrl_q[`CTRL_CHK_SFD];
  assign cfg.strip = ctrl_q[`CTRL_STRIP];
  assign cfg.ign_fcs = ctrl_q[`CTRL_IGN_FCS];
  assign cfg.resync = resync_q;
  assign cfg.max_len = maxlen_q;
  assign cfg.min_len = minlen_q;
  assign cfg.marker_spacing_m1 = spacing_q;
endmodule
`default_nettype wire

// File: testbench/link_partner.sv
`timescale 1ns/1ps
`default_nettype none
// far-side model: remote partner handing decoded words to the receive path
module link_partner (
  input wire logic sys_clk,
  output logic in_valid,
  output logic in_sop,
  output logic in_eop,
  output rx_ctl_pkg::mty_type in_mty,
  output logic [63:0] in_data,
  output logic [63:0] in_preamble,
  output logic in_fcs_bad,
  output logic [3:0] lane_valid,
  output logic [255:0] lane_data
);
  import rx_ctl_pkg::*;
  // idle link at time zero
  initial begin
    in_valid = 1'h0;
    in_sop = 1'h0;
    in_eop = 1'h0;
    in_mty = 3'h0;
    in_data = 64'h0;
    in_preamble = 64'h0;
    in_fcs_bad = 1'h0;
    lane_valid = 4'h0;
    lane_data = 256'h0;
  end
  // one frame of len bytes, words back to back, no gaps
  task automatic send(input int len, input logic bad, input logic [63:0] pre);
    int w;
    w = (len + 7) / 8;
    for (int i = 0; i < w; i++) begin
      @(posedge sys_clk);
      in_valid <= 1'h1;
      in_sop <= (i == 0);
      in_eop <= (i == w - 1);
      in_mty <= 3'(w * 8 - len);
      in_data <= 64'(i);
      in_preamble <= pre;
      in_fcs_bad <= bad;
    end
    @(posedge sys_clk);
    in_valid <= 1'h0;
    in_sop <= 1'h0;
    in_eop <= 1'h0;
    // released lines show no stale word
    in_data <= ~in_data;
    in_preamble <= ~pre;
  endtask
  // lane 0 stream: n markers, each followed by gap filler words
  task automatic markers(input logic [63:0] pat, input int gap, input int n);
    for (int j = 0; j < n; j++) begin
      for (int i = 0; i <= gap; i++) begin
        @(posedge sys_clk);
        lane_valid <= 4'h1;
        lane_data <= {192'h0, ((i == 0) ? pat : ~pat)};
      end
    end
    @(posedge sys_clk);
    lane_valid <= 4'h0;
  endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "rx_ctl_consts.svh"
module testbench;
  import rx_ctl_pkg::*;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, perr, gerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic in_valid, in_sop, in_eop, in_fcs_bad, out_valid, out_sop, out_eop, out_err;
  logic pcs_decode_hold, realign_restart, rate_40g, stat_good, stat_bad, stat_bad_fcs;
  mty_type in_mty, out_mty;
  logic [63:0] in_data, in_preamble, out_data;
  logic [3:0] marker_spacing_error, lane_valid;
  logic [255:0] lane_data;
  logic fsop; // sop flag of a frame's first delivered word
  logic [31:0] fdat; // low half of that word
  // check tallies and counts kept by the output monitor
  int fail_count = 0, total_checks = 0, nfr = 0, acc = 0, glen = 0, nbf = 0, nst = 0, ngd = 0;
  localparam logic [63:0] GOOD_PRE = {`SFD_VAL, `PREAMBLE_VAL};
  rx_path_ctl dut (.sys_clk, .rst, .ce(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .lane_valid, .lane_data, .in_valid, .in_sop,
    .in_eop, .in_mty, .in_data, .in_preamble, .in_fcs_bad, .out_valid, .out_sop, .out_eop,
    .out_mty, .out_data, .out_err, .pcs_decode_hold, .realign_restart, .rate_40g,
    .stat_good, .stat_bad, .stat_bad_fcs, .marker_spacing_error);
  link_partner partner (.sys_clk, .in_valid, .in_sop, .in_eop, .in_mty, .in_data,
    .in_preamble, .in_fcs_bad, .lane_valid, .lane_data);
  // clock source
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // verdict and end of run
  task automatic wrap_up();
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard: running out of cycles counts as a mismatch
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    wrap_up();
  end
  // monitor: rebuild delivered frame length, first word, error, stat pulses
  always @(posedge sys_clk) begin
    if (stat_bad_fcs === 1'h1) nbf++;
    if (stat_good === 1'h1) ngd++;
    if (stat_good === 1'h1 || stat_bad === 1'h1) nst++;
    if (out_valid === 1'h1) begin
      if (acc == 0) begin
        fsop = out_sop;
        fdat = out_data[31:0];
      end
      acc += (out_eop === 1'h1) ? 8 - out_mty : 8;
      if (out_eop === 1'h1) begin
        nfr++;
        glen = acc;
        acc = 0;
        gerr = out_err;
      end
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one bus transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'h1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // send a frame and judge count, length and error of what comes out
  task automatic frame(input int len, input logic bad, input logic [63:0] pre, input int en,
      input int el, input logic ee);
    int n0;
    n0 = nfr;
    partner.send(len, bad, pre);
    repeat (6) @(posedge sys_clk);
    chk("frames", nfr - n0, en);
    if (en > 0) begin
      chk("length", glen, el);
      chk("frame_err", gerr, ee);
      chk("first_sop", fsop, 1'h1);
      chk("first_word", fdat, 32'h0);
    end
  endtask
  task automatic t_regs();
    apb(1'h0, `OFF_MAXLEN, 32'h0);
    chk("maxlen", rd, 32'h2580);
    apb(1'h0, `OFF_SPACING, 32'h0);
    chk("spacing", rd, 32'h3FFF);
    apb(1'h0, 8'h14, 32'h0);
    chk("slverr", perr, 1'h1);
    apb(1'h1, `OFF_CTRL, 32'h3);
    @(posedge sys_clk);
    chk("rate", rate_40g, 1'h1);
    apb(1'h1, `OFF_CTRL, 32'h2);
    @(posedge sys_clk);
    chk("rate", rate_40g, 1'h0);
  endtask
  task automatic t_len();
    frame(24, 1'h0, GOOD_PRE, 1, 24, 1'h1);
    apb(1'h1, `OFF_MINLEN, 32'h40);
    frame(64, 1'h0, GOOD_PRE, 1, 64, 1'h0);
    frame(15, 1'h0, GOOD_PRE, 0, 0, 1'h0);
    apb(1'h1, `OFF_MAXLEN, 32'h40);
    frame(80, 1'h0, GOOD_PRE, 1, 64, 1'h1);
    apb(1'h1, `OFF_MAXLEN, 32'h2580);
  endtask
  task automatic t_fcs();
    int n, g;
    frame(64, 1'h1, GOOD_PRE, 1, 64, 1'h1);
    apb(1'h1, `OFF_CTRL, 32'h22);
    n = nbf;
    g = ngd;
    frame(64, 1'h1, GOOD_PRE, 1, 64, 1'h0);
    chk("bad_fcs_stat", nbf - n, 1);
    chk("good_stat", ngd - g, 1);
    // strip set here together with a receive path reset; strip alone takes hold at the next frame start
    apb(1'h1, `OFF_CTRL, 32'h52);
    frame(64, 1'h0, GOOD_PRE, 1, 60, 1'h0);
  endtask
  task automatic t_pre();
    apb(1'h1, `OFF_CTRL, 32'h46);
    frame(64, 1'h0, GOOD_PRE ^ 64'h1, 1, 64, 1'h1);
    apb(1'h1, `OFF_CTRL, 32'hA);
    frame(64, 1'h0, GOOD_PRE ^ {8'h1, 56'h0}, 1, 64, 1'h1);
    apb(1'h1, `OFF_CTRL, 32'h2);
    frame(64, 1'h0, GOOD_PRE ^ 64'h1, 1, 64, 1'h0);
  endtask
  task automatic t_off();
    int n;
    apb(1'h1, `OFF_CTRL, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("decode_hold", pcs_decode_hold, 1'h1);
    n = nst;
    frame(24, 1'h0, GOOD_PRE, 0, 0, 1'h0);
    chk("stats_off", nst - n, 0);
    apb(1'h1, `OFF_CTRL, 32'h42);
    n = 0;
    repeat (6) begin
      @(posedge sys_clk);
      if (realign_restart === 1'h1) n++;
    end
    chk("restart", n, 1);
  endtask
  // lane 0 markers: on time, then early, then back on time
  task automatic t_lane();
    apb(1'h1, `OFF_SPACING, 32'h3);
    apb(1'h1, `OFF_PATTERN, 32'h5A);
    // new spacing and pattern apply at once; the receive path reset clears the marker checkers
    apb(1'h1, `OFF_CTRL, 32'h42);
    partner.markers(64'h5A, 3, 3);
    @(posedge sys_clk);
    chk("spacing_ok", marker_spacing_error, 4'h0);
    partner.markers(64'h5A, 2, 2);
    @(posedge sys_clk);
    chk("spacing_bad", marker_spacing_error, 4'h1);
    partner.markers(64'h5A, 3, 2);
    @(posedge sys_clk);
    chk("spacing_clear", marker_spacing_error, 4'h0);
  endtask
  // main sequence
  initial begin
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'h0;
    apb(1'h0, `OFF_CTRL, 32'h0);
    chk("ctrl", rd, 32'h2);
    apb(1'h0, `OFF_MINLEN, 32'h0);
    chk("minlen", rd, 32'h40);
    t_regs();
    t_len();
    t_fcs();
    t_pre();
    t_off();
    t_lane();
    wrap_up();
  end
endmodule
`default_nettype wire
